// File: rtl/bscrc_defs.svh
// Register offsets, field positions, reset values and sizes of the CRC unit.
`ifndef BSCRC_DEFS_SVH
`define BSCRC_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define BSCRC_OFF_CONTROL      8'h00
`define BSCRC_OFF_INPUT        8'h04
`define BSCRC_OFF_DATA         8'h08
`define BSCRC_OFF_AUTO         8'h0C
`define BSCRC_OFF_COUNT        8'h10
`define BSCRC_OFF_STATUS       8'h14

// ----------------------------------------
// Control and auto register fields
// ----------------------------------------
`define BSCRC_CTL_PNT_LSB      0
`define BSCRC_CTL_VAL_BIT      2
`define BSCRC_CTL_INIT_BIT     3
`define BSCRC_CTL_SEL_BIT      4
`define BSCRC_AUTO_EN_BIT      7

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define BSCRC_CTL_RESET        8'h00
`define BSCRC_POLY16           16'h1021
`define BSCRC_POLY32_REFL      32'hEDB88320
`define BSCRC_SECTOR_BYTES     1024
`define BSCRC_PAGE_ADDR_LSB    10

`endif

// File: rtl/bscrc_engine.sv
// One-byte update of the running CRC in either polynomial mode.
`timescale 1ns/1ps
`default_nettype none
module bscrc_engine
(
   // Current state and input
   input  wire logic [31:0] crc_in,
   input  wire logic [7:0]  data_byte,
   input  wire logic        mode16,
   // Next state
   output logic      [31:0] crc_out
);
`include "bscrc_defs.svh"

   // ----------------------------------------
   // Bit-serial folding, unrolled by loop
   // ----------------------------------------
   function automatic logic [15:0] step16(input logic [15:0] acc, input logic [7:0] b);
      logic [15:0] a;
      a = acc ^ {b, 8'h00};                                         // see RQ4
      for (int i = 0; i < 8; i++)
         a = a[15] ? ((a << 1) ^ `BSCRC_POLY16) : (a << 1);         // see RQ3, see RQ5
      return a;
   endfunction : step16

   function automatic logic [31:0] step32(input logic [31:0] acc, input logic [7:0] b);
      logic [31:0] a;
      a = acc ^ {24'h000000, b};                                    // see RQ7
      for (int i = 0; i < 8; i++)
         a = a[0] ? ((a >> 1) ^ `BSCRC_POLY32_REFL) : (a >> 1);     // see RQ6, see RQ8
      return a;
   endfunction : step32

   wire logic [15:0] next16 = step16(crc_in[15:0], data_byte);
   wire logic [31:0] next32 = step32(crc_in, data_byte);

   // The upper half is kept in 16-bit mode so a mode switch does not lose it.
   assign crc_out = mode16 ? {crc_in[31:16], next16} : next32;     // see RQ9
endmodule : bscrc_engine
`default_nettype wire

// File: rtl/bscrc_pkg.sv
// Types shared by the CRC unit files.
package bscrc_pkg;
   typedef enum logic [1:0] {BSCRC_IDLE, BSCRC_FETCH, BSCRC_FOLD} bscrc_auto_e;
   typedef logic [31:0] bscrc_word_t;
endpackage : bscrc_pkg

// File: rtl/bscrc_result_mux.sv
// Byte selection of the result for the pointer-addressed data register.
`timescale 1ns/1ps
`default_nettype none
module bscrc_result_mux
(
   // Selection
   input  wire logic [31:0] result,
   input  wire logic [1:0]  pointer,
   input  wire logic        mode16,
   // Selected byte
   output logic      [7:0]  data_byte
);
   wire logic [1:0] eff = mode16 ? {1'b0, pointer[0]} : pointer;
   assign data_byte = result[eff*8 +: 8];                           // see RQ20
endmodule : bscrc_result_mux
`default_nettype wire

// File: rtl/bscrc_top.sv
// AXI4-Lite CRC unit with software byte input and automatic flash CRC.
// ----------------------------------------
// Summary of operation
// RQ1: Software bytes enter through the input register.
// RQ2: Result reached via pointer and data register.
// RQ3: 16-bit mode uses polynomial 0x1021, MSB first.
// RQ4: 16-bit: byte XORed into upper result byte.
// RQ5: 16-bit: shift left, XOR poly if MSB.
// RQ6: 32-bit mode uses reflected 0x04C11DB7.
// RQ7: 32-bit: byte XORed into low result byte.
// RQ8: 32-bit: shift right, XOR 0xEDB88320 if LSB.
// RQ9: Select bit: 0 is 32-bit, 1 is 16-bit.
// RQ10: Value bit chooses zeros or ones start.
// RQ11: Writing initialize loads selected start value.
// RQ12: Software picks polynomial, value, then initializes.
// RQ13: Each input write updates result automatically; an input write during an automatic run leaves it unchanged.
// RQ14: Software sets start page and auto enable.
// RQ15: Sector count given; each sector 1024 bytes.
// RQ16: Control write with auto enabled starts run.
// RQ17: Processor stalled until automatic run ends.
// RQ18: Software clears auto enable before reading.
// RQ19: Software sets bank select, runs from common.
// RQ20: Pointer picks result byte, increments per access.
// RQ21: Result held until init, overwrite or input.
// RQ22: Auto run fetches ascending bytes through engine.
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bscrc_top
   import bscrc_pkg::*;
#(
   parameter int FLASH_AW = 17
)
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // AXI4-Lite write address
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Flash read port
   input  wire logic [1:0]          instruction_bank_select,
   output logic [FLASH_AW-1:0]      flash_addr,
   output logic                     flash_req,
   input  wire logic [7:0]          flash_rdata,
   input  wire logic                flash_rvalid,
   // Processor stall
   output logic                     cpu_stall
);
   import bscrc_pkg::*;
`include "bscrc_defs.svh"

   // ----------------------------------------
   // Reset synchroniser
   // ----------------------------------------
   logic rst_meta_r;
   logic rst_sync_r;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   wire logic rst_n_i = rst_sync_r;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic              sel_r;
   logic              val_r;
   logic [1:0]        pnt_r;
   logic [7:0]        in_r;
   bscrc_word_t       result_r;
   logic [7:0]        auto_r;
   logic [7:0]        count_r;
   bscrc_auto_e       state_r;
   logic [17:0]       bytes_left_r;
   logic [FLASH_AW-1:0] addr_r;
   logic [7:0]        aw_addr_r;
   logic [31:0]       w_data_r;
   logic [3:0]        w_strb_r;
   logic              aw_full_r;
   logic              w_full_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;

   // ----------------------------------------
   // Write channel capture
   // ----------------------------------------
   // Address and data may arrive in either order; each is held until both are in.
   assign s_axi_awready = !aw_full_r && !bvalid_r;
   assign s_axi_wready  = !w_full_r && !bvalid_r;
   wire logic aw_take = s_axi_awvalid && s_axi_awready;
   wire logic w_take  = s_axi_wvalid && s_axi_wready;
   wire logic have_aw = aw_full_r || aw_take;
   wire logic have_w  = w_full_r || w_take;
   wire logic [7:0]  wr_addr = aw_full_r ? aw_addr_r : s_axi_awaddr;
   wire logic [31:0] wr_data = w_full_r ? w_data_r : s_axi_wdata;
   wire logic [3:0]  wr_strb = w_full_r ? w_strb_r : s_axi_wstrb;
   wire logic wr_fire = have_aw && have_w;
   wire logic wr_lane0 = wr_strb[0];
   wire logic [7:0] wr_byte = wr_data[7:0];

   wire logic wr_ctl   = wr_fire && wr_addr == `BSCRC_OFF_CONTROL;
   wire logic wr_in    = wr_fire && wr_addr == `BSCRC_OFF_INPUT  && wr_lane0;
   wire logic wr_dat   = wr_fire && wr_addr == `BSCRC_OFF_DATA   && wr_lane0;
   wire logic wr_auto  = wr_fire && wr_addr == `BSCRC_OFF_AUTO   && wr_lane0;
   wire logic wr_cnt   = wr_fire && wr_addr == `BSCRC_OFF_COUNT  && wr_lane0;
   wire logic wr_known = wr_addr == `BSCRC_OFF_CONTROL || wr_addr == `BSCRC_OFF_INPUT
                      || wr_addr == `BSCRC_OFF_DATA || wr_addr == `BSCRC_OFF_AUTO
                      || wr_addr == `BSCRC_OFF_COUNT || wr_addr == `BSCRC_OFF_STATUS;
   wire logic wr_ctl_l = wr_ctl && wr_lane0;

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   assign s_axi_arready = !rvalid_r;
   wire logic rd_take = s_axi_arvalid && s_axi_arready;
   wire logic rd_dat  = rd_take && s_axi_araddr == `BSCRC_OFF_DATA;
   wire logic [7:0] mux_byte;
   wire logic [7:0] ctl_view = {3'b000, sel_r, 1'b0, val_r, pnt_r};
   wire logic busy = state_r != BSCRC_IDLE;
   logic [31:0] rd_word;
   logic        rd_ok;
   always_comb
   begin
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         `BSCRC_OFF_CONTROL : rd_word = {24'h000000, ctl_view};
         `BSCRC_OFF_INPUT   : rd_word = {24'h000000, in_r};
         `BSCRC_OFF_DATA    : rd_word = {24'h000000, mux_byte};    // see RQ2
         `BSCRC_OFF_AUTO    : rd_word = {24'h000000, auto_r};
         `BSCRC_OFF_COUNT   : rd_word = {24'h000000, count_r};
         `BSCRC_OFF_STATUS  : rd_word = {31'h00000000, busy};
         default :
         begin
            rd_word = 32'h00000000;
            rd_ok   = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Byte engine and result selection
   // ----------------------------------------
   wire logic [7:0] fold_byte = busy ? flash_rdata : wr_byte;      // see RQ22
   wire logic [31:0] folded;
   bscrc_engine u_engine
   (
      .crc_in    (result_r),
      .data_byte (fold_byte),
      .mode16    (sel_r),
      .crc_out   (folded)
   );
   bscrc_result_mux u_mux
   (
      .result    (result_r),
      .pointer   (pnt_r),
      .mode16    (sel_r),
      .data_byte (mux_byte)
   );

   // ----------------------------------------
   // Automatic flash sequencer
   // ----------------------------------------
   wire logic start_auto = wr_ctl && auto_r[`BSCRC_AUTO_EN_BIT] && !busy;   // see RQ16
   wire logic [17:0] run_bytes = {count_r, 10'h000};              // see RQ15
   wire logic auto_fold = state_r == BSCRC_FOLD && flash_rvalid;
   wire logic [FLASH_AW-1:0] start_addr =
      FLASH_AW'({instruction_bank_select, auto_r[6:0], 10'h000});
   bscrc_auto_e state_nxt;
   always_comb
   begin
      case (state_r)
         BSCRC_IDLE  : state_nxt = (start_auto && count_r != 8'h00) ? BSCRC_FETCH : BSCRC_IDLE;
         BSCRC_FETCH : state_nxt = BSCRC_FOLD;
         BSCRC_FOLD  : state_nxt = !flash_rvalid ? BSCRC_FOLD
                                 : (bytes_left_r == 18'h00001) ? BSCRC_IDLE : BSCRC_FETCH;
         default     : state_nxt = BSCRC_IDLE;
      endcase
   end
   assign flash_req  = state_r == BSCRC_FETCH;
   assign flash_addr = addr_r;
   assign cpu_stall  = busy;                                        // see RQ17

   // ----------------------------------------
   // Result and pointer next values
   // ----------------------------------------
   wire logic init_now = wr_ctl_l && wr_byte[`BSCRC_CTL_INIT_BIT];
   wire logic new_val  = wr_ctl_l ? wr_byte[`BSCRC_CTL_VAL_BIT] : val_r;
   wire logic [1:0] dat_slot = sel_r ? {1'b0, pnt_r[0]} : pnt_r;
   logic [31:0] result_nxt;
   always_comb
   begin
      result_nxt = result_r;                                        // see RQ21
      if (init_now)
         result_nxt = new_val ? 32'hFFFFFFFF : 32'h00000000;        // see RQ10, see RQ11
      else if (auto_fold || (wr_in && !busy))
         result_nxt = folded;                                       // see RQ1, see RQ13
      else if (wr_dat)
         result_nxt[dat_slot*8 +: 8] = wr_byte;
   end
   wire logic [1:0] pnt_nxt = wr_ctl_l ? wr_byte[1:0]
                            : (wr_dat || rd_dat) ? pnt_r + 2'b01 : pnt_r;   // see RQ20

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sel_r   <= 1'b0;
         val_r   <= 1'b0;
         pnt_r   <= 2'b00;
         in_r    <= 8'h00;
         result_r <= 32'h00000000;
         auto_r  <= 8'h00;
         count_r <= 8'h00;
      end
      else
      begin
         if (wr_ctl_l)
         begin
            sel_r <= wr_byte[`BSCRC_CTL_SEL_BIT];                  // see RQ9
            val_r <= wr_byte[`BSCRC_CTL_VAL_BIT];
         end
         if (wr_in)
            in_r <= wr_byte;
         if (wr_auto)
            auto_r <= wr_byte;                                      // see RQ14
         if (wr_cnt)
            count_r <= wr_byte;
         pnt_r    <= pnt_nxt;
         result_r <= result_nxt;
      end
   end

   always_ff @(posedge clock or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r      <= BSCRC_IDLE;
         bytes_left_r <= 18'h00000;
         addr_r       <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         if (start_auto)
         begin
            bytes_left_r <= run_bytes;
            addr_r       <= start_addr;                             // see RQ22
         end
         else if (auto_fold)
         begin
            bytes_left_r <= bytes_left_r - 18'h00001;
            addr_r       <= addr_r + FLASH_AW'(1);
         end
      end
   end

   // ----------------------------------------
   // Bus handshake registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h00000000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'b00;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h00000000;
         rresp_r   <= 2'b00;
      end
      else
      begin
         if (aw_take)
            aw_addr_r <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         aw_full_r <= have_aw && !wr_fire;
         w_full_r  <= have_w && !wr_fire;
         if (wr_fire)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_known ? 2'b00 : 2'b10;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
         if (rd_take)
         begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_ok ? 2'b00 : 2'b10;
         end
         else if (s_axi_rready)
            rvalid_r <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;
endmodule : bscrc_top
`default_nettype wire

// File: test/bscrc_assertions.sv
// Concurrent checks on the ports of the CRC unit top.
`timescale 1ns/1ps
`default_nettype none
module bscrc_assertions
#(
   parameter int FLASH_AW = 17
)
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Register bus
   input  wire logic                s_axi_awvalid,
   input  wire logic                s_axi_awready,
   input  wire logic                s_axi_wvalid,
   input  wire logic                s_axi_wready,
   input  wire logic                s_axi_bvalid,
   input  wire logic                s_axi_arvalid,
   input  wire logic                s_axi_arready,
   input  wire logic                s_axi_rvalid,
   input  wire logic [31:0]         s_axi_rdata,
   // Flash port and stall
   input  wire logic [FLASH_AW-1:0] flash_addr,
   input  wire logic                flash_req,
   input  wire logic                flash_rvalid,
   input  wire logic                cpu_stall
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_wr_pair;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_fold_fetch;
      flash_rvalid ##1 flash_req;
   endsequence
   AST_WR_ANSWER: assert property (s_wr_pair |=> s_axi_bvalid)
      else $error("write response missing after write");
   AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write taken while response pending");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
      else $error("read answer late or upper bits set");
   AST_REQ_STALLED: assert property (flash_req |-> cpu_stall)
      else $error("flash fetch outside a stalled run");
   AST_REQ_PULSE: assert property (flash_req |=> !flash_req)
      else $error("fetch request longer than one cycle");
   AST_RUN_STARTS: assert property ($rose(cpu_stall) |-> flash_req)
      else $error("run began without a fetch");
   AST_ADDR_HELD: assert property (cpu_stall && $past(cpu_stall)
      && !$past(flash_rvalid) |-> $stable(flash_addr))
      else $error("fetch address moved before byte taken");
   AST_ADDR_STEP: assert property (s_fold_fetch
      |-> flash_addr == $past(flash_addr) + 1'b1)
      else $error("fetch address did not step by one");
   AST_STALL_EXIT: assert property ($fell(cpu_stall) |-> $past(flash_rvalid))
      else $error("stall dropped without a final byte");
endmodule : bscrc_assertions
bind bscrc_top bscrc_assertions #(.FLASH_AW(FLASH_AW)) i_bscrc_assertions (.clock(clock),
   .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rdata(s_axi_rdata), .flash_addr(flash_addr), .flash_req(flash_req),
   .flash_rvalid(flash_rvalid), .cpu_stall(cpu_stall));
`default_nettype wire

// File: test/bscrc_flash_model.sv
// Behavioural flash that answers byte fetches after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module bscrc_flash_model
(
   // Clock, reset and pace
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [1:0]  delay,
   // Fetch port
   input  wire logic [16:0] flash_addr,
   input  wire logic        flash_req,
   output logic      [7:0]  flash_rdata,
   output logic             flash_rvalid
);
   logic       busy_r;
   logic [1:0] wait_r;
   // Idle data shows the inverse of the last byte so a late sample is caught.
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         busy_r <= 1'b0;
         wait_r <= 2'h0;
         flash_rvalid <= 1'b0;
         flash_rdata <= 8'h00;
      end
      else
      begin
         flash_rvalid <= 1'b0;
         if (flash_rvalid)
            flash_rdata <= ~flash_rdata;
         if (flash_req)
         begin
            busy_r <= 1'b1;
            wait_r <= delay;
         end
         else if (busy_r && wait_r != 2'h0)
            wait_r <= wait_r - 2'h1;
         else if (busy_r)
         begin
            busy_r <= 1'b0;
            flash_rvalid <= 1'b1;
            flash_rdata <= flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3C;
         end
      end
endmodule : bscrc_flash_model
`default_nettype wire

// File: test/bscrc_top_tb.sv
// Self-checking bench for the CRC unit top with a flash model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module bscrc_top_tb;
   logic        clock = 1'b0, rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, b, fl_data;
   logic [31:0] wdata = 32'h0, rdata, acc;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, sel, val;
   logic        awready, wready, bvalid, arready, rvalid, fl_req, fl_rvalid, cpu_stall;
   logic [1:0]  bresp, rresp, bank = 2'h0, delay = 2'h0;
   logic [6:0]  page;
   logic [16:0] fl_addr, exp_addr;
   logic [33:0] ex;
   logic [33:0] q_r[$];
   logic [1:0]  q_b[$];
   int          n_errors = 0, checks = 0, nbytes = 0, n;

   bscrc_top #(.FLASH_AW(17)) i_bscrc_top (.clock(clock), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .instruction_bank_select(bank), .flash_addr(fl_addr), .flash_req(fl_req),
      .flash_rdata(fl_data), .flash_rvalid(fl_rvalid), .cpu_stall(cpu_stall));
   bscrc_flash_model i_bscrc_flash_model (.clock(clock), .rst_n(rst_n), .delay(delay),
      .flash_addr(fl_addr), .flash_req(fl_req), .flash_rdata(fl_data),
      .flash_rvalid(fl_rvalid));

   initial
   begin
      forever #25 clock = ~clock;
   end

   function automatic logic [31:0] upd(input logic [31:0] c, input logic [7:0] d, input logic m16);
      if (m16) c[15:8] ^= d; else c[7:0] ^= d;
      for (int i = 0; i < 8; i++)
         if (m16) c = {16'h0, c[14:0], 1'b0} ^ (c[15] ? 32'h1021 : 32'h0);
         else c = (c >> 1) ^ (c[0] ? 32'hEDB88320 : 32'h0);
      return c;
   endfunction : upd

   // Bus cycles are sampled at the falling edge so the outcome never races the rising edge.
   // A bus cycle waits for its answer however long it takes; only the watchdog ends a hang.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] e);
      logic ta, tw, tk;
      if (w)
      begin
         q_b.push_back(e[33:32]);
         awaddr  <= a;
         wdata   <= d;
         awvalid <= 1'b1;
         wvalid  <= 1'b1;
      end
      else
      begin
         q_r.push_back(e);
         araddr  <= a;
         arvalid <= 1'b1;
      end
      do
      begin
         @(negedge clock);
         ta = w ? awready : arready;
         tw = wready;
         tk = w ? bvalid : rvalid;
         @(posedge clock);
         if (ta && w)
            awvalid <= 1'b0;
         if (ta && !w)
            arvalid <= 1'b0;
         if (tw && w)
            wvalid <= 1'b0;
      end
      while (!tk);
   endtask : bus

   // Two passes over the result bytes; the control read shows where the pointer ended.
   task automatic readout(input logic [1:0] p);
      for (int k = 0; k < (sel ? 4 : 8); k++)
         bus(0, 8'h08, 32'h0, {26'h0, acc[8 * ((p + k) % (sel ? 2 : 4)) +: 8]});
      bus(0, 8'h00, 32'h0, {29'h0, sel, 1'b0, val, p});
   endtask : readout

   task final_report;
      if (n_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report

   always @(negedge clock)
   begin
      if (rvalid)
      begin
         ex = q_r.pop_front();
         `CHK("read data", ex, {rresp, rdata})
      end
      if (bvalid)
      begin
         ex = {q_b.pop_front(), 32'h0};
         `CHK("write response", ex[33:32], bresp)
      end
      if (fl_rvalid)
      begin
         `CHK("fetch address", exp_addr, fl_addr)
         exp_addr++;
         nbytes++;
         acc = upd(acc, fl_data, sel);
      end
   end

   initial
   begin
      repeat (60000) @(posedge clock);
      n_errors++;
      final_report;
   end

   initial
   begin
      void'($urandom(14141));
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (int m = 0; m < 4; m++)
      begin
         sel = m[1];
         val = m[0];
         acc = val ? 32'hFFFFFFFF : 32'h0;
         bus(1, 8'h00, {27'h0, sel, 1'b1, val, 2'b00}, 34'h0);
         repeat (3 + $urandom % 4)
         begin
            b = $urandom;
            bus(1, 8'h04, {24'h0, b}, 34'h0);
            acc = upd(acc, b, sel);
         end
         readout(2'h0);
      end
      // Known single-byte vectors from an all-ones start, one per polynomial.
      for (int m = 0; m < 2; m++)
      begin
         sel = m[0];
         val = 1'b1;
         acc = sel ? 32'hFFFFBD35 : 32'hF9462090;
         bus(1, 8'h00, {27'h0, sel, 4'hC}, 34'h0);
         bus(1, 8'h04, 32'h63, 34'h0);
         readout(2'h0);
      end
      sel = 1'b0;
      val = 1'b0;
      acc = 32'h0;
      b = $urandom;
      bus(1, 8'h00, {27'h0, 5'b01001}, 34'h0);
      bus(1, 8'h08, {24'h0, b}, 34'h0);
      acc[15:8] = b;
      readout(2'h2);
      bus(1, 8'h18, 32'h1, {2'b10, 32'h0});
      bus(0, 8'h1C, 32'h0, {2'b10, 32'h0});
      bus(0, 8'h14, 32'h0, 34'h0);
      for (int m = 0; m < 2; m++)
      begin
         sel = m[0];
         val = 1'b1;
         acc = 32'hFFFFFFFF;
         bank <= 2'($urandom);
         delay <= 2'($urandom);
         page = $urandom % 126;
         bus(1, 8'h00, {27'h0, sel, 2'b11, 2'b00}, 34'h0);
         bus(1, 8'h0C, {24'h0, 1'b1, page}, 34'h0);
         bus(1, 8'h10, 32'h1 + m, 34'h0);
         exp_addr = 17'({bank, page, 10'h0});
         nbytes = 0;
         bus(1, 8'h00, {27'h0, sel, 2'b01, 2'b00}, 34'h0);
         @(negedge clock);
         `CHK("stall", 1'b1, cpu_stall)
         n = 0;
         while (cpu_stall === 1'b1 && n < 20000)
         begin
            @(negedge clock);
            n++;
         end
         `CHK("fetched bytes", 1024 * (1 + m), nbytes)
         @(posedge clock);
         bus(1, 8'h0C, {24'h0, 1'b0, page}, 34'h0);
         readout(2'h0);
      end
      final_report;
   end
endmodule : bscrc_top_tb
`default_nettype wire
